// ===== rtl/maio_consts.svh
// Purpose: Offsets, field positions, reset values and timing of the axis I/O block
// Assumes: APB byte addresses, one 32-bit word per register
// Notes:   Function
// Function
// - reset puts each axis in two-pulse output; software may pick pulse-plus-direction
// - each pulse pin has a negative twin that is always its inverse
// - the four general outputs are off while reset is held
// - two general outputs may show accel/decel, two may show compare results
// - plus limit halts plus pulses, minus limit minus; level and stop kind settable
// - after reset the limit inputs are read as active low
// - mode register two bit 3 picks limit polarity; 0 means active low
// - enabled stop input 1-3 stops: decelerating when ramping, immediate at constant speed
// - mode register three bits 6,7 set 1,0 enable stop input 3 active low
// - four stop inputs per axis; input 0 is Z phase, 1-3 home inputs
// - enabled active alarm sets the alarm status bit and stops driving at once
// - with in-position enabled, driving flag stays set until in-position, alarm or emergency stop is active
// - limit, stop, in-position and alarm levels are readable in two level registers
// - encoder A/B count the real position, quadrature or up/down pulses
// - enabled active Z phase input stops pulse output; level is settable
// - encoder counting keeps up with two-phase input up to 4 MHz
// - jog: fixed mode outputs the set count, continuous runs while input low
// - emergency stop halts every axis and flags error on each that was driving
`ifndef MAIO_CONSTS_SVH
`define MAIO_CONSTS_SVH
`define MAIO_NAX        4
// Per axis window: axis * 0x20 + offset
`define MAIO_OFF_MODE2  5'h00
`define MAIO_OFF_MODE3  5'h04
`define MAIO_OFF_CMD    5'h08
`define MAIO_OFF_PCNT   5'h0C
`define MAIO_OFF_RATE   5'h10
`define MAIO_OFF_COMPP  5'h14
`define MAIO_OFF_COMPM  5'h18
`define MAIO_OFF_RPOS   5'h1C
// Global registers
`define MAIO_OFF_MAIN   8'h80
`define MAIO_OFF_LVL1   8'h84
`define MAIO_OFF_LVL2   8'h88
`define MAIO_OFF_ISTAT  8'h8C
`define MAIO_OFF_IMASK  8'h90
`define MAIO_OFF_STAT2  8'h94
`define MAIO_OFF_CTRL   8'h98
// Mode register two fields
`define MAIO_M2_LIMSUD  0
`define MAIO_M2_LIMPOL  3
`define MAIO_M2_ENCUD   4
`define MAIO_M2_PDIR    5
`define MAIO_M2_ALMEN   12
`define MAIO_M2_ALMPOL  13
`define MAIO_M2_INPEN   14
`define MAIO_M2_INPPOL  15
// Mode register three fields: stop input k enable at 2k, polarity at 2k+1
`define MAIO_M3_JOGEN   8
`define MAIO_M3_JOGCON  9
`define MAIO_M3_GPACC   10
`define MAIO_M3_GPCMP   11
`define MAIO_M3_GPLO    12
// Command register bits
`define MAIO_CMD_PLUS   0
`define MAIO_CMD_MINUS  1
`define MAIO_CMD_DSTOP  2
`define MAIO_CMD_SSTOP  3
`define MAIO_CMD_CLR    4
`define MAIO_CMD_CONT   5
// Reset values and ramp span
`define MAIO_RST_MODE2  16'h0000
`define MAIO_RST_MODE3  16'h0000
`define MAIO_RST_RATE   16'h0063
`define MAIO_RAMP       16'h0010
// Timing
`define MAIO_CLK_MHZ    200
`define MAIO_ENC_MHZ    4
`define MAIO_ENC_CYC    (`MAIO_CLK_MHZ / `MAIO_ENC_MHZ)
`endif

// ===== rtl/maio_pkg.sv
// Purpose: Types shared by the axis I/O block
// Assumes: Constants come from maio_consts.svh
// Notes:   Pin groups travel as packed structs
package maio_pkg;
  typedef struct packed {
    logic       plus_limit_input;
    logic       minus_limit_input;
    logic       stop_input_3;
    logic       stop_input_2;
    logic       stop_input_1;
    logic       zphase_stop_input;
    logic       servo_positioned_input;
    logic       servo_fault_input;
    logic       encoder_a_input;
    logic       encoder_b_input;
    logic       ext_jog_plus;
    logic       ext_jog_minus;
  } maio_pins_t;
  typedef struct packed {
    logic       plus_pulse_pos;
    logic       plus_pulse_neg;
    logic       minus_pulse_pos;
    logic       minus_pulse_neg;
    logic       gp_output_7;
    logic       gp_output_6;
    logic       gp_output_5;
    logic       gp_output_4;
  } maio_outs_t;
  typedef enum logic [2:0] {
    MAIO_IDLE  = 3'b000,
    MAIO_ACCEL = 3'b001,
    MAIO_CONST = 3'b010,
    MAIO_DECEL = 3'b011,
    MAIO_INPOS = 3'b100
  } maio_state_t;
endpackage : maio_pkg

// ===== rtl/maio_top.sv
// Purpose: Four-axis pulse output, stop inputs and encoder counting with APB registers
// Assumes: All pins asynchronous to clk_sys; APB master on clk_sys
// Notes:   Zero-wait APB slave, access phase always one cycle
//
// Decided for this implementation: the APB register port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "maio_consts.svh"
module maio_top (
  input  wire logic                          clk_sys,
  input  wire logic                          rst_n,
  input  wire logic                          psel,
  input  wire logic                          penable,
  input  wire logic                          pwrite,
  input  wire logic [7:0]                    paddr,
  input  wire logic [31:0]                   pwdata,
  output logic                               pready,
  output logic [31:0]                        prdata,
  output logic                               pslverr,
  input  wire maio_pkg::maio_pins_t [`MAIO_NAX-1:0] axisPins,
  input  wire logic                          emergency_stop_input,
  output maio_pkg::maio_outs_t [`MAIO_NAX-1:0] axisOuts,
  output logic                               irq
);
  localparam int NAX = `MAIO_NAX;
  // Synchroniser stages; stage 3 only serves edge detection
  maio_pkg::maio_pins_t [NAX-1:0] s1;
  maio_pkg::maio_pins_t [NAX-1:0] s2;
  maio_pkg::maio_pins_t [NAX-1:0] s3;
  logic                           emg1;
  logic                           emg2;
  logic [15:0]                    mode2 [NAX];
  logic [15:0]                    mode3 [NAX];
  logic [31:0]                    pcnt  [NAX];
  logic [15:0]                    rate  [NAX];
  logic [31:0]                    compP [NAX];
  logic [31:0]                    compM [NAX];
  logic [31:0]                    rpos  [NAX];
  logic [NAX-1:0]                 drv;
  logic [NAX-1:0]                 errBit;
  logic [NAX-1:0]                 almBit;
  logic [NAX-1:0]                 limHit;
  logic [7:0]                     lvl   [NAX];
  logic [4*NAX-1:0]               evt;
  logic [4*NAX-1:0]               istat;
  logic [4*NAX-1:0]               imask;
  logic                           emgHigh;
  logic                           wrEn;
  logic                           emgAct;
  logic [31:0]                    rdVal;
  logic                           rdErr;

  // Per-axis register hit
  function automatic logic axHit(input logic [7:0] a, input int k, input logic [4:0] off);
    axHit = (a[7] == 1'b0) && (a[6:5] == k[1:0]) && (a[4:0] == off);
  endfunction : axHit

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s1   <= '0;
      s2   <= '0;
      s3   <= '0;
      emg1 <= 1'b0;
      emg2 <= 1'b0;
    end
    else
    begin
      s1   <= axisPins;
      s2   <= s1;
      s3   <= s2;
      emg1 <= emergency_stop_input;
      emg2 <= emg1;
    end
  end

  // APB: setup cycle loads answer, access cycle shows it
  assign wrEn = psel & penable & pready & pwrite;
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pready  <= 1'b0;
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end
    else
    begin
      pready  <= psel & ~penable;
      pslverr <= psel & ~penable & rdErr;
      if (psel & ~penable & ~pwrite)
        prdata <= rdVal;
    end
  end

  // Read decode; unmapped addresses answer with an error
  always_comb
  begin
    rdVal = 32'h0000_0000;
    rdErr = 1'b0;
    if (!paddr[7])
    begin
      case (paddr[4:0])
        `MAIO_OFF_MODE2: rdVal = {16'h0000, mode2[paddr[6:5]]};
        `MAIO_OFF_MODE3: rdVal = {16'h0000, mode3[paddr[6:5]]};
        `MAIO_OFF_CMD:   rdVal = 32'h0000_0000;
        `MAIO_OFF_PCNT:  rdVal = pcnt[paddr[6:5]];
        `MAIO_OFF_RATE:  rdVal = {16'h0000, rate[paddr[6:5]]};
        `MAIO_OFF_COMPP: rdVal = compP[paddr[6:5]];
        `MAIO_OFF_COMPM: rdVal = compM[paddr[6:5]];
        `MAIO_OFF_RPOS:  rdVal = rpos[paddr[6:5]];
        default:         rdErr = 1'b1;
      endcase
    end
    else
    begin
      case (paddr)
        `MAIO_OFF_MAIN:  rdVal = {24'h000000, errBit, drv};
        `MAIO_OFF_LVL1:  rdVal = {16'h0000, lvl[1], lvl[0]};
        `MAIO_OFF_LVL2:  rdVal = {16'h0000, lvl[3], lvl[2]};
        `MAIO_OFF_ISTAT: rdVal = {16'h0000, istat};
        `MAIO_OFF_IMASK: rdVal = {16'h0000, imask};
        `MAIO_OFF_STAT2: rdVal = {24'h000000, limHit, almBit};
        `MAIO_OFF_CTRL:  rdVal = {31'h00000000, emgHigh};
        default:         rdErr = 1'b1;
      endcase
    end
  end

  // Global control, interrupt status and mask; a new event beats a clear
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      emgHigh <= 1'b0;
      istat   <= '0;
      imask   <= '0;
      irq     <= 1'b0;
    end
    else
    begin
      if (wrEn && paddr == `MAIO_OFF_CTRL)
        emgHigh <= pwdata[0];
      if (wrEn && paddr == `MAIO_OFF_IMASK)
        imask <= pwdata[4*NAX-1:0];
      if (wrEn && paddr == `MAIO_OFF_ISTAT)
        istat <= (istat & ~pwdata[4*NAX-1:0]) | evt;
      else
        istat <= istat | evt;
      irq <= |(istat & imask);
    end
  end

  // Jumper-style level select for the emergency input
  assign emgAct = emgHigh ? emg2 : ~emg2;

  for (genvar k = 0; k < NAX; k++)
  begin : g_axis
    maio_pkg::maio_state_t st;
    logic [15:0] curDiv;
    logic [15:0] divCnt;
    logic [31:0] remain;
    logic        dir;
    logic        cont;
    logic        stopReq;
    logic        pulse;
    logic        limPA;
    logic        limMA;
    logic        almA;
    logic        inpA;
    logic [3:0]  stopA;
    logic        immStop;
    logic        decStop;
    logic        running;
    logic        periodEnd;
    logic        cmdWr;
    logic        jogGo;
    logic        jogRel;
    logic [15:0] startDiv;
    logic [3:0]  ab;
    logic        inc;
    logic        dec;
    logic        wasDrv;

    assign cmdWr    = wrEn && axHit(paddr, k, `MAIO_OFF_CMD);
    assign startDiv = rate[k] + `MAIO_RAMP;
    assign running  = (st == maio_pkg::MAIO_ACCEL) || (st == maio_pkg::MAIO_CONST) ||
                      (st == maio_pkg::MAIO_DECEL);
    assign periodEnd = running && (divCnt >= curDiv);
    // limit polarity, 0 reads active low
    assign limPA = mode2[k][`MAIO_M2_LIMPOL] ? s2[k].plus_limit_input
                                              : ~s2[k].plus_limit_input;
    assign limMA = mode2[k][`MAIO_M2_LIMPOL] ? s2[k].minus_limit_input
                                              : ~s2[k].minus_limit_input;
    assign almA = mode2[k][`MAIO_M2_ALMEN] &
                  (mode2[k][`MAIO_M2_ALMPOL] ? s2[k].servo_fault_input
                                             : ~s2[k].servo_fault_input);
    assign inpA = mode2[k][`MAIO_M2_INPPOL] ? s2[k].servo_positioned_input
                                            : ~s2[k].servo_positioned_input;
    for (genvar j = 0; j < 4; j++)
    begin : g_stop
      logic lv;
      assign lv = (j == 0) ? s2[k].zphase_stop_input :
                  (j == 1) ? s2[k].stop_input_1 :
                  (j == 2) ? s2[k].stop_input_2 : s2[k].stop_input_3;
      assign stopA[j] = mode3[k][2*j] & (mode3[k][2*j+1] ? lv : ~lv);
    end
    assign lvl[k] = {s2[k].servo_fault_input, s2[k].servo_positioned_input,
                     s2[k].stop_input_3, s2[k].stop_input_2, s2[k].stop_input_1,
                     s2[k].zphase_stop_input, s2[k].minus_limit_input,
                     s2[k].plus_limit_input};

    // immediate stops, limit in the moving direction only
    // stop inputs 1-3 decelerate only while ramping
    always_comb
    begin
      immStop = stopA[0] | almA | emgAct | (cmdWr & pwdata[`MAIO_CMD_SSTOP]);
      decStop = cmdWr & pwdata[`MAIO_CMD_DSTOP];
      if ((!dir && limPA) || (dir && limMA))
      begin
        if (mode2[k][`MAIO_M2_LIMSUD])
          immStop = 1'b1;
        else
          decStop = 1'b1;
      end
      if (|stopA[3:1])
      begin
        if (st == maio_pkg::MAIO_CONST)
          immStop = 1'b1;
        else
          decStop = 1'b1;
      end
    end

    // jog edges and release from synchronised stages
    assign jogGo  = mode3[k][`MAIO_M3_JOGEN] &
                    ((s3[k].ext_jog_plus & ~s2[k].ext_jog_plus) |
                     (s3[k].ext_jog_minus & ~s2[k].ext_jog_minus));
    assign jogRel = mode3[k][`MAIO_M3_JOGEN] & mode3[k][`MAIO_M3_JOGCON] & cont &
                    s2[k].ext_jog_plus & s2[k].ext_jog_minus;

    // Software registers of this axis
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
      if (!rst_n)
      begin
        mode2[k] <= `MAIO_RST_MODE2;
        mode3[k] <= `MAIO_RST_MODE3;
        pcnt[k]  <= 32'h0000_0000;
        rate[k]  <= `MAIO_RST_RATE;
        compP[k] <= 32'h0000_0000;
        compM[k] <= 32'h0000_0000;
      end
      else if (wrEn)
      begin
        if (axHit(paddr, k, `MAIO_OFF_MODE2)) mode2[k] <= pwdata[15:0];
        if (axHit(paddr, k, `MAIO_OFF_MODE3)) mode3[k] <= pwdata[15:0];
        if (axHit(paddr, k, `MAIO_OFF_PCNT))  pcnt[k]  <= pwdata;
        if (axHit(paddr, k, `MAIO_OFF_RATE))  rate[k]  <= (pwdata[15:0] == 16'h0000) ?
                                                          16'h0001 : pwdata[15:0];
        if (axHit(paddr, k, `MAIO_OFF_COMPP)) compP[k] <= pwdata;
        if (axHit(paddr, k, `MAIO_OFF_COMPM)) compM[k] <= pwdata;
      end
    end

    // Drive sequencer with linear ramp of the pulse period
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
      if (!rst_n)
      begin
        st      <= maio_pkg::MAIO_IDLE;
        curDiv  <= 16'h0001;
        divCnt  <= 16'h0000;
        remain  <= 32'h0000_0000;
        dir     <= 1'b0;
        cont    <= 1'b0;
        stopReq <= 1'b0;
      end
      else
      begin
        case (st)
          maio_pkg::MAIO_IDLE:
          begin
            if ((cmdWr && (pwdata[`MAIO_CMD_PLUS] | pwdata[`MAIO_CMD_MINUS])) || jogGo)
            begin
              dir     <= cmdWr ? pwdata[`MAIO_CMD_MINUS] : ~s2[k].ext_jog_minus;
              cont    <= cmdWr ? pwdata[`MAIO_CMD_CONT] : mode3[k][`MAIO_M3_JOGCON];
              remain  <= pcnt[k];
              curDiv  <= startDiv;
              divCnt  <= 16'h0000;
              stopReq <= 1'b0;
              st      <= maio_pkg::MAIO_ACCEL;
            end
          end
          maio_pkg::MAIO_INPOS:
          begin
            // hold driving until the servo reports in position, or an alarm or emergency stop is active
            if (inpA || emgAct || almA)
              st <= maio_pkg::MAIO_IDLE;
          end
          default:
          begin
            divCnt <= periodEnd ? 16'h0000 : divCnt + 16'h0001;
            if (periodEnd && !cont)
              remain <= remain - 32'h0000_0001;
            if (periodEnd && st == maio_pkg::MAIO_ACCEL && curDiv > rate[k])
              curDiv <= curDiv - 16'h0001;
            if (periodEnd && st == maio_pkg::MAIO_DECEL && curDiv < startDiv)
              curDiv <= curDiv + 16'h0001;
            if (decStop || jogRel)
              stopReq <= 1'b1;
            if (immStop || (periodEnd && !cont && remain <= 32'h0000_0001) ||
                (periodEnd && st == maio_pkg::MAIO_DECEL && stopReq &&
                 curDiv >= startDiv))
              st <= (mode2[k][`MAIO_M2_INPEN] && !emgAct && !almA) ?
                    maio_pkg::MAIO_INPOS : maio_pkg::MAIO_IDLE;
            else if (decStop || jogRel || stopReq ||
                     (!cont && remain <= 32'({16'h0000, startDiv - curDiv})))
              st <= maio_pkg::MAIO_DECEL;
            else if (st == maio_pkg::MAIO_ACCEL && curDiv <= rate[k])
              st <= maio_pkg::MAIO_CONST;
          end
        endcase
      end
    end

    assign pulse = running && (divCnt <= (curDiv >> 1));
    assign drv[k] = (st != maio_pkg::MAIO_IDLE);
    assign evt[4*k]   = wasDrv & ~drv[k];
    assign evt[4*k+1] = running & ((!dir && limPA) || (dir && limMA));
    assign evt[4*k+2] = almA & ~almBit[k];
    assign evt[4*k+3] = emgAct & drv[k];

    // Sticky status: a new event beats the clear command
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
      if (!rst_n)
      begin
        errBit[k] <= 1'b0;
        almBit[k] <= 1'b0;
        limHit[k] <= 1'b0;
        wasDrv    <= 1'b0;
      end
      else
      begin
        // error on each axis that was driving
        errBit[k] <= (errBit[k] & ~(cmdWr & pwdata[`MAIO_CMD_CLR])) | (emgAct & drv[k]);
        almBit[k] <= (almBit[k] & ~(cmdWr & pwdata[`MAIO_CMD_CLR])) | almA;
        limHit[k] <= (limHit[k] & ~(cmdWr & pwdata[`MAIO_CMD_CLR])) | evt[4*k+1];
        wasDrv    <= drv[k];
      end
    end

    // encoder decode at the system clock, far above 4 MHz
    assign ab  = {s3[k].encoder_a_input, s3[k].encoder_b_input,
                  s2[k].encoder_a_input, s2[k].encoder_b_input};
    always_comb
    begin
      inc = 1'b0;
      dec = 1'b0;
      if (mode2[k][`MAIO_M2_ENCUD])
      begin
        inc = ~ab[3] & ab[1];
        dec = ~ab[2] & ab[0];
      end
      else
      begin
        case (ab)
          4'h1, 4'h7, 4'hE, 4'h8: inc = 1'b1;
          4'h2, 4'hB, 4'hD, 4'h4: dec = 1'b1;
          default:                inc = 1'b0;
        endcase
      end
    end
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
      if (!rst_n)
        rpos[k] <= 32'h0000_0000;
      else if (wrEn && axHit(paddr, k, `MAIO_OFF_RPOS))
        rpos[k] <= pwdata;
      else if (inc && !dec)
        rpos[k] <= rpos[k] + 32'h0000_0001;
      else if (dec && !inc)
        rpos[k] <= rpos[k] - 32'h0000_0001;
    end

    always_ff @(posedge clk_sys or negedge rst_n)
    begin
      if (!rst_n)
      begin
        axisOuts[k] <= 8'b0101_0000;
      end
      else
      begin
        if (mode2[k][`MAIO_M2_PDIR])
        begin
          axisOuts[k].plus_pulse_pos  <= pulse;
          axisOuts[k].plus_pulse_neg  <= ~pulse;
          axisOuts[k].minus_pulse_pos <= dir;
          axisOuts[k].minus_pulse_neg <= ~dir;
        end
        else
        begin
          axisOuts[k].plus_pulse_pos  <= pulse & ~dir;
          axisOuts[k].plus_pulse_neg  <= ~(pulse & ~dir);
          axisOuts[k].minus_pulse_pos <= pulse & dir;
          axisOuts[k].minus_pulse_neg <= ~(pulse & dir);
        end
        axisOuts[k].gp_output_7 <= mode3[k][`MAIO_M3_GPACC] ?
                                   (st == maio_pkg::MAIO_DECEL) : mode3[k][15];
        axisOuts[k].gp_output_6 <= mode3[k][`MAIO_M3_GPACC] ?
                                   (st == maio_pkg::MAIO_ACCEL) : mode3[k][14];
        axisOuts[k].gp_output_5 <= mode3[k][`MAIO_M3_GPCMP] ?
                                   ($signed(rpos[k]) < $signed(compM[k])) : mode3[k][13];
        axisOuts[k].gp_output_4 <= mode3[k][`MAIO_M3_GPCMP] ?
                                   ($signed(rpos[k]) >= $signed(compP[k])) : mode3[k][12];
      end
    end
  end
endmodule : maio_top
`default_nettype wire

// ===== tb/maio_assertions.sv
// Purpose: Port-level checks for the axis I/O block
// Assumes: Pins idle high; limit checks only in immediate limit mode
// Notes:   Mirrors the few mode bits it needs from APB writes
`timescale 1ns/1ps
`default_nettype none
module maio_assertions (
  input wire logic                       clk_sys,
  input wire logic                       rst_n,
  input wire logic                       psel,
  input wire logic                       penable,
  input wire logic                       pwrite,
  input wire logic [7:0]                 paddr,
  input wire logic [31:0]                pwdata,
  input wire logic                       pready,
  input wire logic                       pslverr,
  input wire maio_pkg::maio_pins_t [3:0] axisPins,
  input wire logic                       emergency_stop_input,
  input wire maio_pkg::maio_outs_t [3:0] axisOuts,
  input wire logic                       irq
);
  logic wrDone;
  logic emgHi;
  logic limHi;
  logic limImm;
  default clocking @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);
  assign wrDone = psel && penable && pready && pwrite;
  // Follow stop polarity from bus writes
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      emgHi <= 1'b0;
      limHi <= 1'b0;
      limImm <= 1'b0;
    end
    else if (wrDone && paddr == 8'h98)
      emgHi <= pwdata[0];
    else if (wrDone && paddr == 8'h00)
    begin
      limHi <= pwdata[3];
      limImm <= pwdata[0];
    end
  end
  // Same checks on every axis
  for (genvar k = 0; k < 4; k++)
  begin : gAx
    pulse_pair_a: assert property (
      axisOuts[k].plus_pulse_neg != axisOuts[k].plus_pulse_pos &&
      axisOuts[k].minus_pulse_neg != axisOuts[k].minus_pulse_pos)
      else $error("pulse pair not complementary");
    reset_gp_off_a: assert property ($rose(rst_n) |-> axisOuts[k][3:0] == 4'h0)
      else $error("general outputs on at reset");
    reset_pulse_a: assert property ($rose(rst_n) |-> axisOuts[k][7:4] == 4'h5)
      else $error("pulse pins not idle at reset");
    emg_halt_a: assert property (
      (emergency_stop_input == emgHi)[*6] |-> !$rose(axisOuts[k].plus_pulse_pos))
      else $error("pulse during emergency stop");
  end
  limit_halt_a: assert property (
    (limImm && axisPins[0].plus_limit_input == limHi)[*6]
      |-> !$rose(axisOuts[0].plus_pulse_pos))
    else $error("plus pulse against plus limit");
  mask_quiet_a: assert property (wrDone && paddr == 8'h90 && pwdata == 32'h0 |-> ##2 !irq)
    else $error("interrupt high after masking");
  ready_pulse_a: assert property (psel && !penable |=> pready ##1 !pready)
    else $error("ready not a single pulse");
  unmapped_err_a: assert property (pready |-> pslverr == (paddr > 8'h98))
    else $error("wrong error response");
endmodule : maio_assertions
bind maio_top maio_assertions u_chk (.clk_sys, .rst_n, .psel, .penable, .pwrite, .paddr,
  .pwdata, .pready, .pslverr, .axisPins, .emergency_stop_input, .axisOuts, .irq);
`default_nettype wire

// ===== tb/maio_partner.sv
// Purpose: Motor driver, encoder and switch model for the axis I/O block
// Assumes: The shaft moves one encoder edge per drive pulse
// Notes:   Switches from the bench, encoder from the shaft
`timescale 1ns/1ps
`default_nettype none
module maio_partner (
  input wire maio_pkg::maio_outs_t [3:0] axisOuts,
  input wire maio_pkg::maio_pins_t [3:0] sensed,
  output var maio_pkg::maio_pins_t [3:0] axisPins
);
  int         plusCnt [4] = '{default: 0};
  int         minusCnt [4] = '{default: 0};
  logic [1:0] phase [4] = '{default: 2'h0};
  // Step the shaft per pulse
  for (genvar k = 0; k < 4; k++)
  begin : gAx
    always @(posedge axisOuts[k].plus_pulse_pos)
    begin
      plusCnt[k]++;
      phase[k] = phase[k] + 2'h1;
    end
    always @(posedge axisOuts[k].minus_pulse_pos)
    begin
      minusCnt[k]++;
      phase[k] = phase[k] - 2'h1;
    end
  end
  always_comb
  begin
    axisPins = sensed;
    for (int k = 0; k < 4; k++)
    begin
      axisPins[k].encoder_a_input = phase[k][1];
      axisPins[k].encoder_b_input = phase[k][1] ^ phase[k][0];
    end
  end
endmodule : maio_partner
`default_nettype wire

// ===== tb/testbench.sv
// Purpose: Self-checking bench for the axis I/O block
// Assumes: Zero-wait APB slave; RATE 1 keeps moves short
// Notes:   Stop scenarios use axis 0
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic                       clk_sys = 1'b0;
  logic                       rst_n = 1'b0;
  logic                       psel = 1'b0;
  logic                       penable = 1'b0;
  logic                       pwrite = 1'b0;
  logic [7:0]                 paddr = 8'h00;
  logic [31:0]                pwdata = 32'h0;
  logic                       emgPin = 1'b1;
  logic                       pready, pslverr, irq, lastErr;
  logic [31:0]                prdata, q;
  maio_pkg::maio_pins_t [3:0] sensed = {4{12'hFFF}};
  maio_pkg::maio_pins_t [3:0] axisPins;
  maio_pkg::maio_outs_t [3:0] axisOuts;
  int                         n_mismatch = 0;
  int                         total_checks = 0;
  int                         cyc = 0;
  // 200 MHz clock
  always #2.5 clk_sys = ~clk_sys;
  maio_top DUT (.clk_sys, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .pready,
    .prdata, .pslverr, .axisPins, .emergency_stop_input(emgPin), .axisOuts, .irq);
  maio_partner u_drv (.axisOuts, .sensed, .axisPins);
  // One APB transfer; waits for ready
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    @(posedge clk_sys);
    while (pready !== 1'b1)
      @(posedge clk_sys);
    q = prdata;
    lastErr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("[FAIL] %0t got %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic rdChk(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    check(q, exp);
  endtask : rdChk
  // Poll driving flag
  task automatic waitIdle;
    repeat (4) @(posedge clk_sys);
    for (int i = 0; i < 3000; i++)
    begin
      apb(1'b0, 8'h80, 32'h0);
      if (q[0] === 1'b0)
        break;
    end
  endtask : waitIdle
  // Run axis 0, trip one input
  task automatic runStop(input logic [15:0] m2, m3, input logic [11:0] idle, act,
    input logic [7:0] st2, lvl);
    sensed[0] <= idle;
    apb(1'b1, 8'h00, {16'h0, m2});
    apb(1'b1, 8'h04, {16'h0, m3});
    apb(1'b1, 8'h08, 32'h21);
    repeat (40) @(posedge clk_sys);
    rdChk(8'h80, 32'h1);
    sensed[0] <= act;
    waitIdle;
    rdChk(8'h94, {24'h0, st2});
    rdChk(8'h84, {16'h0, 8'hFF, lvl});
    sensed[0] <= 12'hFFF;
    repeat (4) @(posedge clk_sys);
    apb(1'b1, 8'h08, 32'h10);
  endtask : runStop
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : wrap_up
  // Hang guard
  always @(posedge clk_sys)
  begin
    cyc++;
    if (cyc == 60000)
    begin
      n_mismatch++;
      wrap_up;
    end
  end
  initial
  begin
    repeat (2) @(posedge clk_sys);
    rst_n <= 1'b1;
    @(posedge clk_sys);
    for (int k = 0; k < 4; k++)
      check(axisOuts[k], 8'h50);
    rdChk(8'h00, 32'h0);
    rdChk(8'h10, 32'h63);
    apb(1'b1, 8'h10, 32'h0);
    rdChk(8'h10, 32'h1);
    rdChk(8'h9C, 32'h0);
    check(lastErr, 1'b1);
    // Moves both ways, then pulse+dir
    apb(1'b1, 8'h0C, 32'h3);
    apb(1'b1, 8'h08, 32'h1);
    waitIdle;
    rdChk(8'h1C, 32'h3);
    apb(1'b1, 8'h08, 32'h2);
    waitIdle;
    rdChk(8'h1C, 32'h0);
    check(u_drv.plusCnt[0] * 16 + u_drv.minusCnt[0], 32'h33);
    apb(1'b1, 8'h00, 32'h20);
    apb(1'b1, 8'h08, 32'h2);
    repeat (30) @(posedge clk_sys);
    check(axisOuts[0].minus_pulse_pos, 1'b1);
    waitIdle;
    check(u_drv.plusCnt[0], 32'h6);
    apb(1'b1, 8'h04, 32'hA000);
    repeat (4) @(posedge clk_sys);
    check(axisOuts[0][3:0], 4'hA);
    runStop(16'h0001, 16'h0000, 12'hFFF, 12'h7FF, 8'h10, 8'hFE);
    runStop(16'h0000, 16'h0004, 12'hFFF, 12'hF7F, 8'h00, 8'hF7);
    runStop(16'h0000, 16'h0040, 12'hFFF, 12'hDFF, 8'h00, 8'hDF);
    runStop(16'h0000, 16'h0001, 12'hFFF, 12'hFBF, 8'h00, 8'hFB);
    runStop(16'h1000, 16'h0000, 12'hFFF, 12'hFEF, 8'h01, 8'h7F);
    runStop(16'h0009, 16'h0000, 12'h7FF, 12'hFFF, 8'h10, 8'hFF);
    // In-position holds the driving flag
    apb(1'b1, 8'h00, 32'h4000);
    apb(1'b1, 8'h08, 32'h1);
    repeat (300) @(posedge clk_sys);
    rdChk(8'h80, 32'h1);
    sensed[0] <= 12'hFDF;
    waitIdle;
    check(q, 32'h0);
    sensed[0] <= 12'hFFF;
    // Emergency stop and interrupt
    apb(1'b1, 8'h00, 32'h0);
    apb(1'b1, 8'h8C, 32'hFFFF);
    apb(1'b1, 8'h90, 32'h8);
    apb(1'b1, 8'h08, 32'h21);
    repeat (40) @(posedge clk_sys);
    emgPin <= 1'b0;
    repeat (10) @(posedge clk_sys);
    rdChk(8'h80, 32'h10);
    check(irq, 1'b1);
    apb(1'b1, 8'h90, 32'h0);
    repeat (3) @(posedge clk_sys);
    check(irq, 1'b0);
    emgPin <= 1'b1;
    repeat (4) @(posedge clk_sys);
    apb(1'b1, 8'h08, 32'h10);
    apb(1'b1, 8'h8C, 32'hF);
    apb(1'b1, 8'h90, 32'h8);
    repeat (3) @(posedge clk_sys);
    check(irq, 1'b0);
    rdChk(8'h80, 32'h0);
    wrap_up;
  end
endmodule : testbench
`default_nettype wire
